// ### include/acr_consts.vh
`ifndef ACR_CONSTS_VH
`define ACR_CONSTS_VH
// Register indices as printed; byte address is four times the index
`define ACR_IDX_CTL        12'hf70
`define ACR_IDX_HIGH       12'hf72
`define ACR_IDX_LOW        12'hf73
`define ACR_IDX_INT_STAT   12'hf74
`define ACR_IDX_INT_MASK   12'hf75
// Control register fields
`define ACR_CTL_GO         7
`define ACR_CTL_VREF       5
`define ACR_CTL_REPEAT     4
`define ACR_CTL_CH_HI      3
`define ACR_CTL_CH_LO      0
`define ACR_CTL_RESET      8'h20
`define ACR_CTL_WMASK      6'h3f
// Timing, in system clock cycles
`define ACR_SINGLE_CYC     13'h1409
`define ACR_REPEAT_CYC     13'h0100
`define ACR_IDLE_CYC       13'h00a0
`define ACR_PWRUP_CYC      13'h0028
// Reserved channel codes have both upper bits set
`define ACR_CH_RSVD        2'h3
`endif

// ### logic/acr_adc_regs.v
// Functional notes
// - Repeat bit zero: one conversion, result once after 5129 cycles
// - Repeat bit one: result refreshed every 256 cycles
// - Channel field codes 0 to 11 pick that channel; 11xx reserved
// - High byte register holds upper eight result bits, read-only
// - Full result is high byte above low register bits 7 and 6
// - Reading high byte latches low bits at once; they match it unless a conversion ends in the read's setup cycle
// - Low register keeps bits of last high byte read
// - High byte invalid while a single conversion runs
// - In repeat mode high byte holds last completed value
// - Result bits undefined after reset until a conversion ends
// - Low register bits 5 to 0 reserved, any value
// - Writing go bit one starts or restarts; zero ignored; self clears
// - Every completed conversion raises an interrupt
// - 160 idle cycles power down; next start adds 40 cycles
`timescale 1ns/10ps
`include "acr_consts.vh"

module acr_adc_regs (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire [9:0]  conv_sample,
    output wire [3:0]  channel_select_field,
    output wire        channel_valid,
    output wire        vref_disable,
    output wire        core_powered,
    output wire        core_converting,
    output wire        irq
);

    localparam ST_IDLE  = 2'h0;
    localparam ST_PWRUP = 2'h1;
    localparam ST_CONV  = 2'h2;
    localparam ST_RUN   = 2'h3;

    localparam SEL_NONE = 3'h0;
    localparam SEL_CTL  = 3'h1;
    localparam SEL_HIGH = 3'h2;
    localparam SEL_LOW  = 3'h3;
    localparam SEL_STAT = 3'h4;
    localparam SEL_MASK = 3'h5;

    reg  [7:0]  ctl_reg;
    reg  [7:0]  high_reg;
    reg  [1:0]  pend_low_reg;
    reg  [1:0]  low_reg;
    reg  [1:0]  state_reg;
    reg  [12:0] cnt_reg;
    reg  [12:0] idle_reg;
    reg         powered_reg;
    reg         stat_reg;
    reg         mask_reg;
    reg  [9:0]  smp_a_reg;
    reg  [9:0]  smp_b_reg;
    reg  [9:0]  smp_c_reg;
    reg  [9:0]  smp_hold_reg;
    reg  [31:0] rdata_next;

    wire        access = psel && penable;
    wire        wr     = access && pwrite;
    wire        rd     = access && !pwrite;
    wire        go_wr  = wr && hit(`ACR_IDX_CTL) && pwdata[`ACR_CTL_GO];
    wire        ctl_wr   = wr && hit(`ACR_IDX_CTL);
    wire        high_rd  = rd && hit(`ACR_IDX_HIGH);
    wire        stat_clr = wr && hit(`ACR_IDX_INT_STAT) && pwdata[0];
    wire        mask_wr  = wr && hit(`ACR_IDX_INT_MASK);
    wire        done;

    function hit;
        input [11:0] idx;
        begin
            hit = (paddr[1:0] == 2'h0) && (paddr[13:2] == idx) && (paddr[31:14] == 18'h0);
        end
    endfunction

    // Register select decode for the read mux
    function [2:0] reg_sel;
        input [31:0] addr;
        begin
            if (addr == {18'h0, `ACR_IDX_CTL, 2'h0}) begin
                reg_sel = SEL_CTL;
            end else if (addr == {18'h0, `ACR_IDX_HIGH, 2'h0}) begin
                reg_sel = SEL_HIGH;
            end else if (addr == {18'h0, `ACR_IDX_LOW, 2'h0}) begin
                reg_sel = SEL_LOW;
            end else if (addr == {18'h0, `ACR_IDX_INT_STAT, 2'h0}) begin
                reg_sel = SEL_STAT;
            end else if (addr == {18'h0, `ACR_IDX_INT_MASK, 2'h0}) begin
                reg_sel = SEL_MASK;
            end else begin
                reg_sel = SEL_NONE;
            end
        end
    endfunction

    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign channel_select_field = ctl_reg[`ACR_CTL_CH_HI:`ACR_CTL_CH_LO];
    assign channel_valid = channel_select_field[3:2] != `ACR_CH_RSVD;
    assign vref_disable    = ctl_reg[`ACR_CTL_VREF];
    assign core_powered    = powered_reg;
    assign core_converting = (state_reg == ST_CONV) || (state_reg == ST_RUN);
    assign done = (core_converting && cnt_reg == 13'h1) && !go_wr;
    assign irq  = stat_reg && mask_reg;

    // Sample input from the analog side is synchronised
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            smp_a_reg <= 10'h0;
            smp_b_reg <= 10'h0;
        end else begin
            smp_a_reg <= conv_sample;
            smp_b_reg <= smp_a_reg;
        end
    end

    // Multi-bit crossing: accept a word only once two synchronised copies agree
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            smp_c_reg    <= 10'h0;
            smp_hold_reg <= 10'h0;
        end else begin
            smp_c_reg <= smp_b_reg;
            if (smp_c_reg == smp_b_reg) begin
                smp_hold_reg <= smp_b_reg;
            end
        end
    end

    // Conversion sequencer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg   <= ST_IDLE;
            cnt_reg     <= 13'h0;
            idle_reg    <= 13'h0;
            powered_reg <= 1'b0;
        end else begin
            if (go_wr) begin
                idle_reg <= 13'h0;
                if (powered_reg) begin
                    state_reg <= ST_CONV;
                    cnt_reg   <= `ACR_SINGLE_CYC;
                end else begin
                    powered_reg <= 1'b1;
                    state_reg   <= ST_PWRUP;
                    cnt_reg     <= `ACR_PWRUP_CYC;
                end
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        if (powered_reg) begin
                            if (idle_reg == `ACR_IDLE_CYC - 13'h1) begin
                                powered_reg <= 1'b0;
                                idle_reg    <= 13'h0;
                            end else begin
                                idle_reg <= idle_reg + 13'h1;
                            end
                        end
                    end
                    ST_PWRUP: begin
                        if (cnt_reg == 13'h1) begin
                            state_reg <= ST_CONV;
                            cnt_reg   <= `ACR_SINGLE_CYC;
                        end else begin
                            cnt_reg <= cnt_reg - 13'h1;
                        end
                    end
                    ST_CONV, ST_RUN: begin
                        if (cnt_reg == 13'h1) begin
                            idle_reg <= 13'h0;
                            if (ctl_reg[`ACR_CTL_REPEAT]) begin
                                state_reg <= ST_RUN;
                                cnt_reg   <= `ACR_REPEAT_CYC;
                            end else begin
                                state_reg <= ST_IDLE;
                                cnt_reg   <= 13'h0;
                            end
                        end else begin
                            cnt_reg <= cnt_reg - 13'h1;
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Control register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_reg <= `ACR_CTL_RESET;
        end else begin
            if (ctl_wr) begin
                ctl_reg[5:0] <= pwdata[5:0] & `ACR_CTL_WMASK;
            end
            // go bit set and self clear
            if (go_wr) begin
                ctl_reg[`ACR_CTL_GO] <= 1'b1;
            end else if (done) begin
                ctl_reg[`ACR_CTL_GO] <= 1'b0;
            end
        end
    end

    // Result registers; reset values are arbitrary
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_reg     <= 8'h0;
            pend_low_reg <= 2'h0;
            low_reg      <= 2'h0;
        end else begin
            if (done) begin
                high_reg     <= smp_hold_reg[9:2];
                pend_low_reg <= smp_hold_reg[1:0];
            end
            // latch low bits on high byte read
            if (high_rd) begin
                low_reg <= pend_low_reg;
            end
        end
    end

    // Interrupt status
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_reg <= 1'b0;
        end else begin
            if (done) begin
                stat_reg <= 1'b1;
            end else if (stat_clr) begin
                stat_reg <= 1'b0;
            end
        end
    end

    // Interrupt mask
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= 1'b0;
        end else begin
            if (mask_wr) begin
                mask_reg <= pwdata[0];
            end
        end
    end

    // Read data mux
    always @* begin
        rdata_next = 32'h0;
        case (reg_sel(paddr))
            SEL_CTL: begin
                rdata_next[7:0] = ctl_reg;
            end
            SEL_HIGH: begin
                // content undefined until a conversion ends
                rdata_next[7:0] = high_reg;
            end
            SEL_LOW: begin
                // low bits on 7 and 6, rest zero
                rdata_next[7:0] = {low_reg, 6'h0};
            end
            SEL_STAT: begin
                rdata_next[0] = stat_reg;
            end
            SEL_MASK: begin
                rdata_next[0] = mask_reg;
            end
            default: begin
                rdata_next = 32'h0;
            end
        endcase
    end

    // Read data register, loaded in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdata_next;
        end
    end

endmodule // acr_adc_regs

// ### tb/acr_props.sv
`timescale 1ns/10ps
module acr_props (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire [3:0]  channel_select_field,
    input wire        channel_valid,
    input wire        core_powered,
    input wire        core_converting,
    input wire        irq
);
    logic        rep_q;
    logic [12:0] conv_n;
    logic [8:0]  idle_n;
    wire         wr_acc = psel && penable && pwrite;
    wire         ctl_w = wr_acc && paddr == 32'h3dc0;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence rd_setup(a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    // Run lengths of single conversions and of idle powered spans
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rep_q  <= 1'b0;
            conv_n <= 13'h0;
            idle_n <= 9'h0;
        end else begin
            if (ctl_w)
                rep_q <= pwdata[4];
            conv_n <= (!core_converting || rep_q || (ctl_w && pwdata[7])) ? 13'h0 : conv_n + 13'h1;
            idle_n <= (core_powered && !core_converting) ? idle_n + 9'h1 : 9'h0;
        end
    end
    chan_valid_a: assert property (channel_valid == (channel_select_field[3:2] != 2'h3))
        else $error("channel valid wrong");
    hole_read_a: assert property (rd_setup(32'h3dc4) |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    low_resv_a: assert property (rd_setup(32'h3dcc) |=> prdata[5:0] == 6'h0 && prdata[31:8] == 24'h0)
        else $error("low reserved bits set");
    high_width_a: assert property (rd_setup(32'h3dc8) |=> prdata[31:8] == 24'h0)
        else $error("high byte too wide");
    read_hold_a: assert property (psel && penable && !pwrite |=> $stable(prdata))
        else $error("read data moved");
    irq_cause_a: assert property ($rose(irq) |-> $past(core_converting) || $past(core_converting, 2) || $past(wr_acc) || $past(wr_acc, 2))
        else $error("irq without cause");
    conv_len_a: assert property (conv_n <= 13'h140a)
        else $error("single conversion too long");
    idle_len_a: assert property (idle_n <= 9'h0a1)
        else $error("no power down");
endmodule // acr_props

bind acr_adc_regs acr_props acr_props_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .channel_select_field(channel_select_field), .channel_valid(channel_valid),
    .core_powered(core_powered), .core_converting(core_converting), .irq(irq));

// ### tb/acr_adc_regs_tb_top.sv
`timescale 1ns/10ps
module acr_adc_regs_tb_top;
    localparam logic [31:0] A_CTL = 32'h3dc0;
    localparam logic [31:0] A_HI = 32'h3dc8;
    localparam logic [31:0] A_LO = 32'h3dcc;
    localparam logic [31:0] A_ST = 32'h3dd0;
    localparam logic [31:0] A_MK = 32'h3dd4;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [9:0]  conv_sample = 10'h2b5;
    logic [31:0] rd;
    wire  [31:0] prdata;
    wire  [3:0]  chan;
    wire         pready, valid, vref, pwr, irq;
    int          errors = 0, num_checks = 0, n;
    always #50 pclk = ~pclk;
    acr_adc_regs acr_adc_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(), .conv_sample(conv_sample),
        .channel_select_field(chan), .channel_valid(valid), .vref_disable(vref),
        .core_powered(pwr), .core_converting(), .irq(irq));
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic wirq();
        n = 0;
        while (irq !== 1'b1 && n < 9000) begin
            @(posedge pclk);
            #1;
            n++;
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #3000000;
        errors++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rchk("ctl", A_CTL, 32'h20);
        chk("vref", 32'h1, {31'h0, vref});
        for (int i = 0; i < 16; i++) begin
            xfer(1'b1, A_CTL, i);
            chk("chan", i, {28'h0, chan});
            chk("valid", 32'(i < 12), {31'h0, valid});
        end
        xfer(1'b1, A_MK, 32'h1);
        xfer(1'b1, A_CTL, 32'h83);
        wirq();
        chk("cold", 32'h1, 32'(n == 5169 || n == 5170));
        rchk("go", A_CTL, 32'h03);
        conv_sample <= 10'h3c7;
        rchk("high", A_HI, 32'had);
        rchk("low", A_LO, 32'h40);
        xfer(1'b1, A_HI, 32'hff);
        rchk("ro", A_HI, 32'had);
        rchk("stat", A_ST, 32'h1);
        xfer(1'b1, A_ST, 32'h1);
        chk("irqclr", 32'h0, {31'h0, irq});
        xfer(1'b1, A_CTL, 32'h90);
        wirq();
        chk("warm", 32'h1, 32'(n == 5129 || n == 5130));
        xfer(1'b1, A_ST, 32'h1);
        wirq();
        chk("period", 32'h1, 32'(n == 253));
        rchk("rhigh", A_HI, 32'hf1);
        conv_sample <= 10'h002;
        xfer(1'b1, A_ST, 32'h1);
        wirq();
        rchk("keep", A_LO, 32'hc0);
        rchk("nhigh", A_HI, 32'h00);
        rchk("nlow", A_LO, 32'h80);
        xfer(1'b1, A_CTL, 32'h00);
        rchk("hole", 32'h3dc4, 32'h0);
        repeat (500) @(posedge pclk);
        #1;
        chk("pdown", 32'h0, {31'h0, pwr});
        chk("irqon", 32'h1, {31'h0, irq});
        xfer(1'b1, A_MK, 32'h0);
        chk("mask", 32'h0, {31'h0, irq});
        close_out();
    end
endmodule // acr_adc_regs_tb_top
